/* design/tap_pkg.sv */
// Constants and types shared by the memory test access port
package tap_pkg;

    // ------------------------------------------------------------
    // Chain lengths
    // ------------------------------------------------------------
    localparam int IR_LEN  = 3;
    localparam int ID_LEN  = 32;
    localparam int BSR_LEN = 73;

    // ------------------------------------------------------------
    // Instruction codes
    // ------------------------------------------------------------
    localparam logic [2:0] IR_EXTEST   = 3'h0;
    localparam logic [2:0] IR_IDCODE   = 3'h1;
    localparam logic [2:0] IR_SAMPLE_Z = 3'h2;
    localparam logic [2:0] IR_RSVD_3   = 3'h3;
    localparam logic [2:0] IR_SAMPLE   = 3'h4;
    localparam logic [2:0] IR_RSVD_5   = 3'h5;
    localparam logic [2:0] IR_RSVD_6   = 3'h6;
    localparam logic [2:0] IR_BYPASS   = 3'h7;

    // Value taken by the instruction shifter in capture-IR
    localparam logic [2:0] IR_CAPTURE  = 3'h1;

    // Identity word; the upper 31 bits are arbitrary, bit 0 must stay set
    localparam logic [31:0] ID_DEFAULT = 32'h5A3C0F01;

    // Bypass bit capture value
    localparam logic BYP_CAPTURE = 1'b0;

    // Consecutive high mode-select edges that force reset
    localparam int RESET_EDGES = 5;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        TLR, RTI,
        SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
    } tap_state_t;

    typedef enum logic [1:0] {
        SEL_BSR, SEL_ID, SEL_BYP
    } chain_sel_t;

    // Effective serial inputs after the pull-ups
    typedef struct packed {
        logic tms;
        logic tdi;
    } tap_pins_t;

endpackage

/* design/sram_boundary_scan_tap.sv */
// Serial boundary scan test access port of the synchronous memory
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Inputs sampled on rising test clock; serial outputs change on falling edge.
// - Mode select and data in read high when left undriven.
// - Serial data enters chain MSB; serial data leaves from chain LSB.
// - Five high mode-select edges reset the port without touching memory.
// - Power-up reset leaves serial data out in high impedance.
// - Three-bit instruction, loaded with ID instruction on any reset.
// - Capture-instruction loads the two low instruction bits with 01.
// - Exactly one data register is selected by the instruction.
// - Bypass path is one bit, cleared to zero under bypass.
// - Boundary chain is 73 bits, captures pins, shifts in shift-data.
// - ID instruction captures hardwired 32-bit code, shifts it out.
// - New instruction takes effect only through update-instruction.
// - All-zero code acts as sample and floats memory outputs.
// - Never drives memory; extest only captures pins, with no update stage.
// - Sample-with-high-Z selects boundary chain and floats memory outputs.
// - Sample captures all input and bidirectional pins in capture-data.
// - Update-data under sample acts like pause-data: nothing happens.
// - Bypass instruction puts the one-bit path in shift-data.
// - Serial out driver enable follows the controller state.
// - ID instruction is encoded 001.
// - State moves follow mode select at each rising test clock.

module sram_boundary_scan_tap
    import tap_pkg::*;
#(
    parameter logic [31:0] ID_CODE = ID_DEFAULT
)(
    input  wire logic               sys_clk,
    input  wire logic               rst,
    input  wire logic               tck,
    input  wire logic               tms_pin,
    input  wire logic               tms_driven,
    input  wire logic               tdi_pin,
    input  wire logic               tdi_driven,
    input  wire logic [BSR_LEN-1:0] ring_pins,
    output var  logic               tdo_out,
    output var  logic               tdo_oe,
    output var  logic               mem_out_hiz
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (ID_CODE[0] != 1'b1) begin : g_id_check
        $error("identity word must end in a one");
    end

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    tap_pins_t          pins;
    tap_state_t         state;
    tap_state_t         next_state;
    logic [IR_LEN-1:0]  ir_shift;
    logic [IR_LEN-1:0]  ir;
    logic [ID_LEN-1:0]  id_shift;
    logic [BSR_LEN-1:0] bsr;
    logic               bypass;
    logic [BSR_LEN-1:0] ring_meta;
    logic [BSR_LEN-1:0] ring_sync;
    chain_sel_t         sel;
    logic               force_hiz;
    logic               hiz_meta;
    logic               chain_lsb;

    // ------------------------------------------------------------
    // Pad pull-ups
    // ------------------------------------------------------------
    // Undriven balls read high, as the internal pull-ups make them
    assign pins = '{tms: tms_pin | ~tms_driven,
                    tdi: tdi_pin | ~tdi_driven};

    // ------------------------------------------------------------
    // Controller state machine
    // ------------------------------------------------------------
    // Standard sixteen-state walk steered by sampled mode select
    always_comb begin
        next_state = state;
        case (state)
            TLR:    next_state = pins.tms ? TLR    : RTI;
            RTI:    next_state = pins.tms ? SEL_DR : RTI;
            SEL_DR: next_state = pins.tms ? SEL_IR : CAP_DR;
            CAP_DR: next_state = pins.tms ? EX1_DR : SH_DR;
            SH_DR:  next_state = pins.tms ? EX1_DR : SH_DR;
            EX1_DR: next_state = pins.tms ? UPD_DR : PAU_DR;
            PAU_DR: next_state = pins.tms ? EX2_DR : PAU_DR;
            EX2_DR: next_state = pins.tms ? UPD_DR : SH_DR;
            UPD_DR: next_state = pins.tms ? SEL_DR : RTI;
            SEL_IR: next_state = pins.tms ? TLR    : CAP_IR;
            CAP_IR: next_state = pins.tms ? EX1_IR : SH_IR;
            SH_IR:  next_state = pins.tms ? EX1_IR : SH_IR;
            EX1_IR: next_state = pins.tms ? UPD_IR : PAU_IR;
            PAU_IR: next_state = pins.tms ? EX2_IR : PAU_IR;
            EX2_IR: next_state = pins.tms ? UPD_IR : SH_IR;
            UPD_IR: next_state = pins.tms ? SEL_DR : RTI;
            default: next_state = TLR;
        endcase
    end

    // Power-up reset parks the controller; five highs reach TLR too
    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            state <= TLR;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Instruction register
    // ------------------------------------------------------------
    // Shifter: capture pattern, then shift from the MSB end
    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            ir_shift <= IR_CAPTURE;
        end else if (state == CAP_IR) begin
            ir_shift <= IR_CAPTURE;
        end else if (state == SH_IR) begin
            ir_shift <= {pins.tdi, ir_shift[IR_LEN-1:1]};
        end
    end

    // Active code changes only at update or on entering reset
    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            ir <= IR_IDCODE;
        end else if (next_state == TLR) begin
            ir <= IR_IDCODE;
        end else if (state == UPD_IR) begin
            ir <= ir_shift;
        end
    end

    // ------------------------------------------------------------
    // Data register select
    // ------------------------------------------------------------
    // Unused codes fall back to bypass so the board chain stays whole
    always_comb begin
        case (ir)
            IR_EXTEST:   sel = SEL_BSR;
            IR_SAMPLE_Z: sel = SEL_BSR;
            IR_SAMPLE:   sel = SEL_BSR;
            IR_IDCODE:   sel = SEL_ID;
            IR_BYPASS:   sel = SEL_BYP;
            default:     sel = SEL_BYP;
        endcase
    end

    // Memory outputs float under the all-zero and sample-Z codes.
    // Registered beside the instruction so the memory clock never
    // samples a decode glitch while several code bits move at once.
    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            force_hiz <= 1'b0; // ID instruction keeps outputs live
        end else if (next_state == TLR) begin
            force_hiz <= 1'b0;
        end else if (state == UPD_IR) begin
            force_hiz <= (ir_shift == IR_EXTEST)
                      || (ir_shift == IR_SAMPLE_Z);
        end
    end

    // ------------------------------------------------------------
    // Pin ring synchroniser
    // ------------------------------------------------------------
    // Pins move with the memory clock; capture sees them two edges late
    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            ring_meta <= '0;
            ring_sync <= '0;
        end else begin
            ring_meta <= ring_pins;
            ring_sync <= ring_meta;
        end
    end

    // ------------------------------------------------------------
    // Boundary scan chain
    // ------------------------------------------------------------
    // Capture only; no update stage, so nothing ever reaches the memory
    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            bsr <= '0;
        end else if (sel == SEL_BSR && state == CAP_DR) begin
            bsr <= ring_sync;
        end else if (sel == SEL_BSR && state == SH_DR) begin
            bsr <= {pins.tdi, bsr[BSR_LEN-1:1]};
        end
    end

    // ------------------------------------------------------------
    // Identification register
    // ------------------------------------------------------------
    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            id_shift <= '0;
        end else if (sel == SEL_ID && state == CAP_DR) begin
            id_shift <= ID_CODE;
        end else if (sel == SEL_ID && state == SH_DR) begin
            id_shift <= {pins.tdi, id_shift[ID_LEN-1:1]};
        end
    end

    // ------------------------------------------------------------
    // Bypass bit
    // ------------------------------------------------------------
    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            bypass <= BYP_CAPTURE;
        end else if (sel == SEL_BYP && state == CAP_DR) begin
            bypass <= BYP_CAPTURE;
        end else if (sel == SEL_BYP && state == SH_DR) begin
            bypass <= pins.tdi;
        end
    end

    // ------------------------------------------------------------
    // Serial output
    // ------------------------------------------------------------
    // Least significant bit of whichever chain is in the path
    always_comb begin
        if (state == SH_IR) begin
            chain_lsb = ir_shift[0];
        end else begin
            case (sel)
                SEL_BSR: chain_lsb = bsr[0];
                SEL_ID:  chain_lsb = id_shift[0];
                default: chain_lsb = bypass;
            endcase
        end
    end

    // Falling edge gives the far end half a period of settle time
    always_ff @(negedge tck or posedge rst) begin
        if (rst) begin
            tdo_out <= 1'b0;
            tdo_oe  <= 1'b0;
        end else begin
            tdo_out <= chain_lsb;
            tdo_oe  <= (state == SH_IR) || (state == SH_DR);
        end
    end

    // ------------------------------------------------------------
    // High-Z request into the memory clock domain
    // ------------------------------------------------------------
    // Level crossing; a few memory clocks of lag are harmless here
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hiz_meta    <= 1'b0;
            mem_out_hiz <= 1'b0;
        end else begin
            hiz_meta    <= force_hiz;
            mem_out_hiz <= hiz_meta;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence tms_held_s;
        pins.tms [*5];
    endsequence

    sequence ir_load_s;
        (state == SH_IR) ##1 (state == EX1_IR) ##1 (state == UPD_IR);
    endsequence

    property reset_walk_p;
        @(posedge tck) disable iff (rst)
        tms_held_s |=> (state == TLR) && (ir == IR_IDCODE);
    endproperty

    property ir_apply_p;
        @(posedge tck) disable iff (rst)
        ir_load_s ##1 (next_state != TLR) |-> ir == $past(ir_shift);
    endproperty

    five_tms_reset_a: assert property (reset_walk_p)
        else $error("five high mode selects did not reset");

    ir_reset_id_a: assert property (
        @(posedge tck) disable iff (rst)
        (state == TLR) |-> (ir == IR_IDCODE))
        else $error("reset state without ID instruction");

    ir_capture_a: assert property (
        @(posedge tck) disable iff (rst)
        (state == CAP_IR) |=> (ir_shift[1:0] == 2'b01))
        else $error("capture-IR pattern wrong");

    ir_update_only_a: assert property (
        @(posedge tck) disable iff (rst)
        !$stable(ir) |-> ($past(state) == UPD_IR) || (state == TLR))
        else $error("instruction changed outside update");

    ir_apply_a: assert property (ir_apply_p)
        else $error("updated instruction not applied");

    bypass_clear_a: assert property (
        @(posedge tck) disable iff (rst)
        (state == CAP_DR) && (sel == SEL_BYP) |=> (bypass == 1'b0))
        else $error("bypass bit not cleared on capture");

    id_capture_a: assert property (
        @(posedge tck) disable iff (rst)
        (state == CAP_DR) && (ir == IR_IDCODE) |=> (id_shift == ID_CODE))
        else $error("identity word not captured");

    bsr_shift_in_a: assert property (
        @(posedge tck) disable iff (rst)
        (state == SH_DR) && (sel == SEL_BSR)
        |=> (bsr[BSR_LEN-1] == $past(pins.tdi))
            && (bsr[BSR_LEN-2:0] == $past(bsr[BSR_LEN-1:1])))
        else $error("boundary chain shift wrong");

    update_dr_idle_a: assert property (
        @(posedge tck) disable iff (rst)
        (state == UPD_DR) |=> $stable(bsr))
        else $error("update-data disturbed the boundary chain");

    reserved_bypass_a: assert property (
        @(posedge tck) disable iff (rst)
        (ir == IR_RSVD_3 || ir == IR_RSVD_5 || ir == IR_RSVD_6)
        |-> (sel == SEL_BYP))
        else $error("reserved code not routed to bypass");

    tdo_enable_a: assert property (
        @(posedge tck) disable iff (rst)
        tdo_oe == ((state == SH_IR) || (state == SH_DR)))
        else $error("serial out enable out of step with state");

    hiz_follow_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        force_hiz [*3] |-> mem_out_hiz)
        else $error("memory high-Z request lost");

    hiz_release_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (!force_hiz) [*3] |-> !mem_out_hiz)
        else $error("memory high-Z held after release");

    hiz_decode_a: assert property (
        @(posedge tck) disable iff (rst)
        force_hiz == ((ir == IR_EXTEST) || (ir == IR_SAMPLE_Z)))
        else $error("high-Z request out of step with instruction");

    bsr_capture_a: assert property (
        @(posedge tck) disable iff (rst)
        (state == CAP_DR) && (sel == SEL_BSR) |=> (bsr == $past(ring_sync)))
        else $error("boundary chain missed the pin ring");

    id_shift_a: assert property (
        @(posedge tck) disable iff (rst)
        (state == SH_DR) && (sel == SEL_ID)
        |=> (id_shift[ID_LEN-1] == $past(pins.tdi))
            && (id_shift[ID_LEN-2:0] == $past(id_shift[ID_LEN-1:1])))
        else $error("identity register shift wrong");

    bypass_shift_a: assert property (
        @(posedge tck) disable iff (rst)
        (state == SH_DR) && (sel == SEL_BYP) |=> (bypass == $past(pins.tdi)))
        else $error("bypass bit did not take serial input");

    tdo_lsb_a: assert property (
        @(posedge tck) disable iff (rst)
        tdo_oe |-> (tdo_out == chain_lsb))
        else $error("serial out not the selected chain LSB");

endmodule
`default_nettype wire

/* testbench/scan_ctl_model.sv */
// Board-side boundary-scan controller model driving the test link
`timescale 1ns/100ps
`default_nettype none
module scan_ctl_model (
    output var  logic tck,
    output var  logic tms_pin,
    output var  logic tms_driven,
    output var  logic tdi_pin,
    output var  logic tdi_driven,
    input  wire logic tdo_out,
    input  wire logic tdo_oe
);
    logic oe_seen;
    logic oe_ok;

    // ------------------------------------------------------------
    // Link idle levels; tck stands low outside frames
    // ------------------------------------------------------------
    initial begin
        tck = 1'b0;
        tms_pin = 1'b1;
        tms_driven = 1'b1;
        tdi_pin = 1'b0;
        tdi_driven = 1'b0;
        oe_seen = 1'b0;
        oe_ok = 1'b1;
    end

    // One 15 ns test clock; levels change just after the falling edge
    task automatic step(input logic m, input logic d, output logic o);
        tms_pin = m;       // Mode select moves the state
        tdi_pin = d;
        #7.5;
        o = tdo_out;       // Taken at the rising edge
        oe_seen = tdo_oe;
        tck = 1'b1;
        #7.5;
        tck = 1'b0;
    endtask

    // Full IR or DR frame from idle back to idle; LSB first
    task automatic scan(input logic ir, input int n,
                        input logic [127:0] din, output logic [127:0] dout);
        logic o;
        dout = '0;
        oe_ok = 1'b1;
        tdi_driven = 1'b0;                 // Released: pull-up, line toggles
        step(1'b1, ~tdi_pin, o);
        if (ir) step(1'b1, ~tdi_pin, o);
        step(1'b0, ~tdi_pin, o);           // Capture state
        step(1'b0, ~tdi_pin, o);           // Into shift
        tdi_driven = 1'b1;
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);   // Last bit exits shift
            dout[i] = o;
            oe_ok &= oe_seen;
        end
        tdi_driven = 1'b0;
        step(1'b1, ~tdi_pin, o);           // Update state
        step(1'b0, ~tdi_pin, o);
    endtask

    // Five high mode edges with the pin left undriven
    task automatic tap_reset();
        logic o;
        tms_driven = 1'b0;
        repeat (5) step(1'b0, ~tdi_pin, o);
        tms_driven = 1'b1;
        step(1'b0, ~tdi_pin, o);
    endtask
endmodule
`default_nettype wire

/* testbench/tb.sv */
// Self-checking bench for the memory test access port
`timescale 1ns/100ps
`default_nettype none
module tb;
    import tap_pkg::*;
    logic               sys_clk, rst, tck, tms_pin, tms_driven;
    logic               tdi_pin, tdi_driven, tdo_out, tdo_oe, mem_out_hiz;
    logic [BSR_LEN-1:0] ring_pins;
    logic [127:0]       din, dout;
    logic [2:0]         code;
    int                 error_cnt, check_count, cycles;
    localparam logic [127:0] MASK80 = (128'h1 << 80) - 128'h1;

    sram_boundary_scan_tap uut (
        .sys_clk     (sys_clk),
        .rst         (rst),
        .tck         (tck),
        .tms_pin     (tms_pin),
        .tms_driven  (tms_driven),
        .tdi_pin     (tdi_pin),
        .tdi_driven  (tdi_driven),
        .ring_pins   (ring_pins),
        .tdo_out     (tdo_out),
        .tdo_oe      (tdo_oe),
        .mem_out_hiz (mem_out_hiz)
    );

    scan_ctl_model ctl (
        .tck        (tck),
        .tms_pin    (tms_pin),
        .tms_driven (tms_driven),
        .tdi_pin    (tdi_pin),
        .tdi_driven (tdi_driven),
        .tdo_out    (tdo_out),
        .tdo_oe     (tdo_oe)
    );

    // ------------------------------------------------------------
    // Clock, hang guard and reporting
    // ------------------------------------------------------------
    initial sys_clk = 1'b0;
    always #50 sys_clk = ~sys_clk;

    // Whole run needs well under a thousand memory cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            finish_test();
        end
    end

    task automatic finish_test();
        if (error_cnt == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: saw %h expected %h",
                     $time, seen, exp);
        end
    endtask

    // Chain contents after an 80-bit shift: capture first, then tdi
    function automatic logic [127:0] exp_dr(input logic [2:0] c,
        input logic [127:0] d, input logic [BSR_LEN-1:0] p);
        logic [127:0] cap;
        int len;
        len = 1;
        cap = '0;
        if (c == IR_IDCODE) begin
            len = ID_LEN;
            cap = 128'(ID_DEFAULT);
        end
        if (c inside {IR_EXTEST, IR_SAMPLE_Z, IR_SAMPLE}) begin
            len = BSR_LEN;
            cap = 128'(p);
        end
        return ((d << len) | cap) & MASK80;
    endfunction

    task automatic id_scan();
        din = {$urandom, $urandom, $urandom, $urandom};
        ctl.scan(1'b0, 80, din, dout);
        chk(dout, exp_dr(IR_IDCODE, din, ring_pins));
    endtask

    // Load one code, then two data frames; the second shows update-DR
    // left nothing behind
    task automatic run_code(input logic [2:0] c);
        @(negedge sys_clk);
        ring_pins = BSR_LEN'({$urandom, $urandom, $urandom});
        ctl.scan(1'b1, IR_LEN, 128'(c), dout);
        chk(dout, 128'(IR_CAPTURE));
        repeat (4) @(negedge sys_clk);
        chk(mem_out_hiz, c == IR_EXTEST || c == IR_SAMPLE_Z);
        repeat (2) begin
            din = {$urandom, $urandom, $urandom, $urandom};
            ctl.scan(1'b0, 80, din, dout);
            chk(dout, exp_dr(c, din, ring_pins));
            chk(ctl.oe_ok, 1'b1);
            @(negedge sys_clk);
            chk(tdo_oe, 1'b0);
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h495A));
        rst = 1'b1;
        ring_pins = '0;
        repeat (3) @(negedge sys_clk);
        chk(tdo_oe, 1'b0);
        rst = 1'b0;
        ctl.tap_reset();
        id_scan();
        // Every code once, reserved ones included
        for (int k = 0; k < 8; k++) begin
            run_code(3'(k));
        end
        // Random legal codes only; reserved ones stay out of the draw
        repeat (6) begin
            code = 3'($urandom_range(4));
            if (code == IR_RSVD_3) begin
                code = IR_SAMPLE;
            end else if (code == IR_SAMPLE) begin
                code = IR_BYPASS;
            end
            run_code(code);
        end
        // Mode-select reset drops the float and restores the ID code
        run_code(IR_EXTEST);
        ctl.tap_reset();
        repeat (4) @(negedge sys_clk);
        chk(mem_out_hiz, 1'b0);
        id_scan();
        // Power reset in mid-run
        run_code(IR_SAMPLE_Z);
        @(negedge sys_clk);
        rst = 1'b1;
        ctl.tap_reset();
        repeat (2) @(negedge sys_clk);
        chk({tdo_oe, mem_out_hiz}, 2'b00);
        rst = 1'b0;
        ctl.tap_reset();
        id_scan();
        finish_test();
    end
endmodule
`default_nettype wire
